// File: verilog/tcc_core.sv
`default_nettype none

module tcc_core #(
  parameter int CNT_W = tcc_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,

  // count clock strobe from the prescaler
  input wire logic count_tick_i,

  // cpu register port
  input wire logic [1:0] reg_sel_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [CNT_W-1:0] reg_wdata_i,
  output logic [CNT_W-1:0] reg_rdata_o,

  // control fields held outside this block
  input wire logic [7:0] op_mode_control_i,
  input wire logic [7:0] capcmp_control_i,
  input wire logic [7:0] prescaler_setup_i,
  input wire logic oneshot_mode_i,
  input wire logic oneshot_sw_trigger_i,

  // timer pins
  input wire logic timer_input_a_i,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe_o,
  input wire logic timer_output_sel_i,
  input wire logic timer_output_level_i,

  // match interrupt requests
  output logic primary_match_irq_o,
  output logic secondary_match_irq_o
);

  typedef struct packed {
    logic [CNT_W-1:0] up_count_value;
    logic [CNT_W-1:0] capcmp_primary;
    logic [CNT_W-1:0] capcmp_secondary;
    logic [CNT_W-1:0] rdata;
    logic pending;
    logic pin_out;
    logic pin_oe;
  } tcc_core_st_t;

  tcc_core_st_t st_r;
  tcc_core_st_t st_nxt;

  // edge strobes of both timer inputs
  tcc_edge_if a_edge ();
  tcc_edge_if b_edge ();

  logic primary_equal;
  logic secondary_equal;
  logic advance;
  logic hold_off;
  logic owed;
  logic running;
  logic a_valid;
  logic b_valid;
  logic primary_trig;
  logic primary_is_capture;
  logic secondary_is_capture;
  logic primary_from_a;
  logic [1:0] a_sel;
  logic [1:0] b_sel;
  logic b_enabled;
  tcc_pkg::tcc_mode_t mode;

  // valid edge as selected: 00 falling, 01 rising, 11 both
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic rise,
    input logic fall
  );
    logic hit;
    hit = 1'b0;
    case (sel)
      tcc_pkg::EDGE_FALL: hit = fall;
      tcc_pkg::EDGE_RISE: hit = rise;
      tcc_pkg::EDGE_BOTH: hit = rise | fall;
      // the one-zero code is forbidden to software and yields nothing
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  // primary captures from input a on the phase opposite a single valid edge; the both code yields nothing
  function automatic logic edge_hit_reverse(
    input logic [1:0] sel,
    input logic rise,
    input logic fall
  );
    logic hit;
    hit = 1'b0;
    case (sel)
      tcc_pkg::EDGE_FALL: hit = rise;
      tcc_pkg::EDGE_RISE: hit = fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit_reverse

  // mode field decode
  always_comb begin
    case (op_mode_control_i[tcc_pkg::OPM_HI -: 2])
      2'h0: mode = tcc_pkg::TCC_STOP;
      2'h1: mode = tcc_pkg::TCC_FREE;
      2'h2: mode = tcc_pkg::TCC_CLR_EDGE;
      default: mode = tcc_pkg::TCC_CLR_MATCH;
    endcase
  end

  assign running = (mode != tcc_pkg::TCC_STOP);

  // control field picks
  assign primary_is_capture = capcmp_control_i[tcc_pkg::CCC_PRI_CAP];
  assign primary_from_a = capcmp_control_i[tcc_pkg::CCC_PRI_SRC];
  assign secondary_is_capture = capcmp_control_i[tcc_pkg::CCC_SEC_CAP];
  assign a_sel = prescaler_setup_i[tcc_pkg::PRS_A_HI:tcc_pkg::PRS_A_LO];
  assign b_sel = prescaler_setup_i[tcc_pkg::PRS_B_HI:tcc_pkg::PRS_B_LO];

  // the shared pin is input b only while it is not the timer output
  assign b_enabled = ~st_r.pin_oe;

  tcc_edge_detect u_edge_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(timer_input_a_i),
    .edge_o(a_edge)
  );

  tcc_edge_detect u_edge_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(shared_port_pin_i),
    .edge_o(b_edge)
  );

  assign a_valid = edge_hit(a_sel, a_edge.rise, a_edge.fall);
  assign b_valid = b_enabled & edge_hit(b_sel, b_edge.rise, b_edge.fall);

  always_comb begin
    if (primary_from_a) begin
      primary_trig = edge_hit_reverse(a_sel, a_edge.rise, a_edge.fall);
    end else begin
      primary_trig = b_valid;
    end
  end

  // a counter read defers any tick by a cycle; the owed tick is kept,
  // though two ticks owed in the same read cycle merge into one
  assign hold_off = reg_rd_i & (reg_sel_i == tcc_pkg::SEL_COUNT);
  assign owed = count_tick_i | st_r.pending;
  assign advance = running & owed & ~hold_off;

  tcc_cmp_unit #(
    .W(CNT_W)
  ) u_cmp_primary (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .count_i(st_r.up_count_value),
    .value_i(st_r.capcmp_primary),
    .compare_en_i(~primary_is_capture),
    .advance_i(advance),
    .equal_o(primary_equal),
    .match_o(primary_match_irq_o)
  );

  tcc_cmp_unit #(
    .W(CNT_W)
  ) u_cmp_secondary (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .count_i(st_r.up_count_value),
    .value_i(st_r.capcmp_secondary),
    .compare_en_i(~secondary_is_capture),
    .advance_i(advance),
    .equal_o(secondary_equal),
    .match_o(secondary_match_irq_o)
  );

  always_comb begin
    st_nxt = st_r;

    // deferred tick bookkeeping
    st_nxt.pending = running & ((owed & hold_off) | (count_tick_i & st_r.pending));

    // counter: clears win over the step
    if (!running) begin
      st_nxt.up_count_value = tcc_pkg::CNT_RST;
    end else if ((mode == tcc_pkg::TCC_CLR_EDGE) && a_valid) begin
      st_nxt.up_count_value = tcc_pkg::CNT_RST;
    end else if (oneshot_mode_i && oneshot_sw_trigger_i) begin
      st_nxt.up_count_value = tcc_pkg::CNT_RST;
    end else if (advance) begin
      if ((mode == tcc_pkg::TCC_CLR_MATCH) && primary_equal) begin
        st_nxt.up_count_value = tcc_pkg::CNT_RST;
      end else begin
        // wraps through all ones, so a value below the count waits a lap
        st_nxt.up_count_value = st_r.up_count_value + 1'b1;
      end
    end

    // software writes are whole 16-bit words
    if (reg_wr_i && (reg_sel_i == tcc_pkg::SEL_PRIMARY)) begin
      st_nxt.capcmp_primary = reg_wdata_i;
    end
    if (reg_wr_i && (reg_sel_i == tcc_pkg::SEL_SECONDARY)) begin
      st_nxt.capcmp_secondary = reg_wdata_i;
    end

    // captures land after writes, so hardware wins a collision
    if (primary_is_capture && primary_trig) begin
      st_nxt.capcmp_primary = st_r.up_count_value;
    end
    if (secondary_is_capture && a_valid) begin
      st_nxt.capcmp_secondary = st_r.up_count_value;
    end

    // read data is taken from the old register values, so a read in the
    // same cycle as a capture returns the value from before the capture
    if (reg_rd_i) begin
      if (reg_sel_i == tcc_pkg::SEL_COUNT) begin
        st_nxt.rdata = st_r.up_count_value;
      end else if (reg_sel_i == tcc_pkg::SEL_PRIMARY) begin
        st_nxt.rdata = st_r.capcmp_primary;
      end else if (reg_sel_i == tcc_pkg::SEL_SECONDARY) begin
        st_nxt.rdata = st_r.capcmp_secondary;
      end else begin
        st_nxt.rdata = tcc_pkg::RD_UNMAPPED;
      end
    end

    // shared pin direction and level
    st_nxt.pin_oe = timer_output_sel_i;
    st_nxt.pin_out = timer_output_sel_i & timer_output_level_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.up_count_value <= tcc_pkg::CNT_RST;
      st_r.capcmp_primary <= tcc_pkg::CAP_RST;
      st_r.capcmp_secondary <= tcc_pkg::CAP_RST;
      st_r.rdata <= tcc_pkg::RD_UNMAPPED;
      st_r.pending <= 1'b0;
      st_r.pin_out <= 1'b0;
      st_r.pin_oe <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign shared_port_pin_o = st_r.pin_out;
  assign shared_port_pin_oe_o = st_r.pin_oe;

endmodule : tcc_core

`default_nettype wire

// File: common/tcc_pkg.sv
`default_nettype none

package tcc_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;
  // register select codes on the cpu port
  localparam logic [1:0] SEL_COUNT = 2'h0;
  localparam logic [1:0] SEL_PRIMARY = 2'h1;
  localparam logic [1:0] SEL_SECONDARY = 2'h2;
  // field positions
  localparam int OPM_LO = 1;
  localparam int OPM_HI = 3;
  localparam int CCC_PRI_CAP = 0;
  localparam int CCC_PRI_SRC = 1;
  localparam int CCC_SEC_CAP = 2;
  localparam int PRS_A_LO = 4;
  localparam int PRS_A_HI = 5;
  localparam int PRS_B_LO = 6;
  localparam int PRS_B_HI = 7;
  // edge-select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {
    TCC_STOP,
    TCC_FREE,
    TCC_CLR_EDGE,
    TCC_CLR_MATCH
  } tcc_mode_t;
endpackage : tcc_pkg

`default_nettype wire

// File: common/tcc_edge_if.sv
`default_nettype none

interface tcc_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport snk (input rise, input fall);
endinterface : tcc_edge_if

`default_nettype wire

// File: verilog/tcc_edge_detect.sv
`default_nettype none

module tcc_edge_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // raw pin
  input wire logic pin_i,
  // edge strobes
  tcc_edge_if.src edge_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
    logic fall;
  } tcc_edge_st_t;

  tcc_edge_st_t st_r;
  tcc_edge_st_t st_nxt;

  // meta feeds only sync; edges are judged on sync against prev
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin_i;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
    st_nxt.rise = st_r.sync & ~st_r.prev;
    st_nxt.fall = ~st_r.sync & st_r.prev;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_o.rise = st_r.rise;
  assign edge_o.fall = st_r.fall;
endmodule : tcc_edge_detect

`default_nettype wire

// File: verilog/tcc_cmp_unit.sv
`default_nettype none

module tcc_cmp_unit #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // compare inputs
  input wire logic [W-1:0] count_i,
  input wire logic [W-1:0] value_i,
  input wire logic compare_en_i,
  input wire logic advance_i,
  // results
  output logic equal_o,
  output logic match_o
);
  typedef struct packed {
    logic match;
  } tcc_cmp_st_t;

  tcc_cmp_st_t st_r;
  tcc_cmp_st_t st_nxt;

  assign equal_o = (count_i == value_i);

  // the match fires as the counter leaves the equal value, so a zero
  // compare fires on the step from zero to one, after a restart or a wrap
  always_comb begin
    st_nxt = st_r;
    st_nxt.match = compare_en_i & advance_i & equal_o;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign match_o = st_r.match;
endmodule : tcc_cmp_unit

`default_nettype wire

// File: tb/tcc_core_assertions.sv
`default_nettype none

module tcc_core_assertions #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // stimulus side
  input wire logic count_tick_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] op_mode_control_i,
  input wire logic [7:0] capcmp_control_i,
  input wire logic timer_output_sel_i,
  // design outputs
  input wire logic [CNT_W-1:0] reg_rdata_o,
  input wire logic shared_port_pin_oe_o,
  input wire logic primary_match_irq_o,
  input wire logic secondary_match_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_stopped;
    op_mode_control_i[3:2] == 2'h0;
  endsequence

  sequence s_rd_count;
    reg_rd_i && reg_sel_i == 2'h0;
  endsequence

  // two stopped cycles so the clear has landed before the read
  a_stop_count_zero: assert property (s_stopped ##1 (s_stopped and s_rd_count) |=>
    reg_rdata_o == '0) else $error("counter not zero while stopped");
  a_stop_no_irq: assert property (s_stopped |=>
    !primary_match_irq_o && !secondary_match_irq_o) else $error("irq while stopped");
  a_pri_irq_pulse: assert property (primary_match_irq_o |=> !primary_match_irq_o)
    else $error("primary irq longer than one cycle");
  a_sec_irq_pulse: assert property (secondary_match_irq_o |=> !secondary_match_irq_o)
    else $error("secondary irq longer than one cycle");
  // a read may defer the tick by one cycle
  a_irq_after_tick: assert property (primary_match_irq_o |->
    $past(count_tick_i) || $past(count_tick_i, 2)) else $error("primary irq without tick");
  a_pri_cap_quiet: assert property ($past(capcmp_control_i[0]) |->
    !primary_match_irq_o) else $error("primary irq in capture mode");
  a_sec_cap_quiet: assert property ($past(capcmp_control_i[2]) |->
    !secondary_match_irq_o) else $error("secondary irq in capture mode");
  a_pin_dir: assert property (1'b1 |=>
    shared_port_pin_oe_o == $past(timer_output_sel_i)) else $error("pin enable wrong");
endmodule : tcc_core_assertions

bind tcc_core tcc_core_assertions #(.CNT_W(CNT_W)) u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .count_tick_i(count_tick_i),
  .reg_sel_i(reg_sel_i),
  .reg_rd_i(reg_rd_i),
  .op_mode_control_i(op_mode_control_i),
  .capcmp_control_i(capcmp_control_i),
  .timer_output_sel_i(timer_output_sel_i),
  .reg_rdata_o(reg_rdata_o),
  .shared_port_pin_oe_o(shared_port_pin_oe_o),
  .primary_match_irq_o(primary_match_irq_o),
  .secondary_match_irq_o(secondary_match_irq_o)
);

`default_nettype wire

// File: tb/tcc_pin_model.sv
`default_nettype none

module tcc_pin_model (
  // clock and requested level
  input wire logic clk_i,
  input wire logic lvl_i,
  // block pin driver
  input wire logic pin_o_i,
  input wire logic pin_oe_i,
  // pins
  output logic timer_input_a_o,
  output logic shared_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl_r = 1'b0;
  initial timer_input_a_o = 1'b0;
  // level is taken on the rising edge, where the bench holds it still, and
  // input a moves on the falling edge; the shared pin follows it there unless the block drives it
  always @(posedge clk_i) begin
    lvl_r <= lvl_i;
  end
  always @(negedge clk_i) begin
    timer_input_a_o <= lvl_r;
  end
  assign shared_pin_o = pin_oe_i ? pin_o_i : timer_input_a_o;
endmodule : tcc_pin_model

`default_nettype wire

// File: tb/tcc_core_tb.sv
`default_nettype none

module tcc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] RISE_AT = 16'h0003;
  localparam logic [15:0] FALL_AT = 16'h0005;
  logic clk, rst_n, tick, rd, wr, ost, osm, osel, lvl;
  logic pin_a, pin_b, pin_o, pin_oe, pirq, sirq, olvl;
  logic [1:0] sel;
  logic [15:0] wdata, rdata, v;
  logic [7:0] opm, ccc, prs;
  logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int pc = 0;
  int sc = 0;
  int n, pb, sb;

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    pc += int'(pirq === 1'b1);
    sc += int'(sirq === 1'b1);
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  tcc_pin_model u_pins (.clk_i(clk), .lvl_i(lvl), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .timer_input_a_o(pin_a), .shared_pin_o(pin_b));
  tcc_core u_dut (.clk_i(clk), .rst_n_i(rst_n), .count_tick_i(tick), .reg_sel_i(sel),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .op_mode_control_i(opm), .capcmp_control_i(ccc), .prescaler_setup_i(prs),
    .oneshot_mode_i(osm), .oneshot_sw_trigger_i(ost), .timer_input_a_i(pin_a),
    .shared_port_pin_i(pin_b), .shared_port_pin_o(pin_o), .shared_port_pin_oe_o(pin_oe),
    .timer_output_sel_i(osel), .timer_output_level_i(olvl),
    .primary_match_irq_o(pirq), .secondary_match_irq_o(sirq));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [1:0] s, input logic [15:0] e);
    sel = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(rdata, e);
    // one idle edge so a following request never re-raises the strobe at once
    @(negedge clk);
  endtask : rd_chk

  task automatic wr_reg(input logic [1:0] s, input logic [15:0] d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg

  // one-cycle ticks with gaps, so a read never swallows one
  task automatic ticks(input int k);
    repeat (k) begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
    end
  endtask : ticks

  task automatic restart(input logic [7:0] m);
    opm = 8'h00;
    @(negedge clk);
    opm = m;
  endtask : restart

  task automatic pin_edges();
    ticks(3);
    lvl = 1'b1;
    repeat (6) @(negedge clk);
    ticks(2);
    lvl = 1'b0;
    repeat (6) @(negedge clk);
  endtask : pin_edges

  function automatic logic [15:0] cap_exp(input logic [1:0] c, input bit rev,
                                          input logic [15:0] keep);
    if (rev) begin
      return (c == 2'h1) ? FALL_AT : ((c == 2'h0) ? RISE_AT : keep);
    end
    return (c == 2'h1) ? RISE_AT : FALL_AT;
  endfunction : cap_exp

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {tick, rd, wr, ost, osm, osel, lvl, olvl} = '0;
    {sel, wdata, opm, ccc, prs} = '0;
    v = 16'($urandom(28891));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(2'h0, 16'h0000);
    rd_chk(2'h1, 16'h0000);
    rd_chk(2'h2, 16'h0000);
    rd_chk(2'h3, 16'h0000);
    wr_reg(2'h2, v);
    rd_chk(2'h2, v);
    wr_reg(2'h0, v);
    rd_chk(2'h0, 16'h0000);
    restart(8'h04);
    n = 1 + $urandom_range(20);
    ticks(n);
    rd_chk(2'h0, 16'(n));
    // a tick that meets a counter read is deferred, not lost
    tick = 1'b1;
    sel = 2'h0;
    rd = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    rd = 1'b0;
    check(rdata, 16'(n));
    @(negedge clk);
    rd_chk(2'h0, 16'(n + 1));
    wr_reg(2'h1, 16'(n + 3));
    wr_reg(2'h2, 16'(n + 5));
    pb = pc;
    sb = sc;
    ticks(2);
    check(16'(pc - pb), 16'h0000);
    ticks(1);
    check(16'(pc - pb), 16'h0001);
    ticks(2);
    check(16'(sc - sb), 16'h0001);
    wr_reg(2'h1, 16'h0001);
    pb = pc;
    ticks(3);
    check(16'(pc - pb), 16'h0000);
    wr_reg(2'h1, 16'h0004);
    restart(8'h0C);
    ticks(5);
    rd_chk(2'h0, 16'h0000);
    restart(8'h04);
    wr_reg(2'h2, 16'h0000);
    sb = sc;
    ticks(1);
    check(16'(sc - sb), 16'h0001);
    ticks(3);
    restart(8'h04);
    rd_chk(2'h0, 16'h0000);
    ticks(3);
    osm = 1'b1;
    ost = 1'b1;
    @(negedge clk);
    ost = 1'b0;
    rd_chk(2'h0, 16'h0000);
    osm = 1'b0;
    prs = 8'h10;
    restart(8'h08);
    ticks(3);
    lvl = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(2'h0, 16'h0000);
    lvl = 1'b0;
    repeat (6) @(negedge clk);
    for (int s = 0; s < 2; s++) begin
      foreach (codes[i]) begin
        v = 16'($urandom);
        ccc = (s == 1) ? 8'h07 : 8'h05;
        wr_reg(2'h1, v);
        prs = {codes[i], codes[i], 4'h0};
        restart(8'h04);
        pin_edges();
        rd_chk(2'h1, cap_exp(codes[i], s[0], v));
        rd_chk(2'h2, cap_exp(codes[i], 1'b0, v));
      end
    end
    // primary captures from input b on both edges, but the pin is an output
    ccc = 8'h01;
    prs = 8'hC0;
    wr_reg(2'h1, v);
    osel = 1'b1;
    olvl = 1'b1;
    repeat (2) @(negedge clk);
    check({15'h0000, pin_oe}, 16'h0001);
    check({15'h0000, pin_o}, 16'h0001);
    olvl = 1'b0;
    repeat (6) @(negedge clk);
    check({15'h0000, pin_o}, 16'h0000);
    rd_chk(2'h1, v);
    osel = 1'b0;
    final_report();
  end
endmodule : tcc_core_tb

`default_nettype wire
